// *** hdl/nv_core_host.sv ***
// Core-side sequencer driving the nonvolatile store port
`timescale 1ns/1ps
`include "nv_defines.svh"
module nv_core_host (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [1:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output wire logic [15:0] o_rdata,
    nv_io_if.core            io
);
    import nv_pkg::*;

    host_state_type st_q;
    nv_addr_type    haddr_q;
    byte_type       hdata_q;
    byte_type       result_q;
    logic [1:0]     op_q;
    logic [1:0]     mode_q;
    logic           gie_q;
    logic           rie_q;
    logic [15:0]    rdata_q;
    io_addr_type    io_addr_q;
    byte_type       io_wdata_q;
    logic           io_wr_q;
    logic           io_rd_q;
    logic           free;
    byte_type       ctrl_base;

    // One strobe at a time, never into a stall
    assign free      = !io.stall && !io_wr_q && !io_rd_q; // R2 R3
    assign ctrl_base = {2'b00, mode_q, rie_q, 3'b000};

    ////////////////////////////////////////////////////////////////////////
    // Command registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            haddr_q <= 9'h000;
            hdata_q <= 8'h00;
            gie_q   <= 1'b0;
            rie_q   <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                `HOST_OFF_ADDR: haddr_q <= i_wdata[8:0];
                `HOST_OFF_DATA: hdata_q <= i_wdata[7:0];
                `HOST_OFF_CFG: begin
                    gie_q <= i_wdata[0];
                    rie_q <= i_wdata[1];
                end
                default: ;
            endcase
        end
    end

    // Status read-back
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_rd) begin
            rdata_q <= 16'h0000;
        end else begin
            case (i_addr)
                `HOST_OFF_ADDR: rdata_q <= {7'h00, haddr_q};
                `HOST_OFF_DATA: rdata_q <= {8'h00, hdata_q};
                `HOST_OFF_CMD:  rdata_q <= {result_q, 6'h00, io.ready_irq, st_q != H_IDLE};
                default:        rdata_q <= {14'h0000, rie_q, gie_q};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q       <= H_IDLE;
            op_q       <= `HOST_OP_READ;
            mode_q     <= `NV_MODE_ATOMIC;
            result_q   <= 8'h00;
            io_addr_q  <= 6'h00;
            io_wdata_q <= 8'h00;
            io_wr_q    <= 1'b0;
            io_rd_q    <= 1'b0;
        end else begin
            io_wr_q <= 1'b0;
            io_rd_q <= 1'b0;
            case (st_q)
                H_IDLE: begin
                    if (i_wr && (i_addr == `HOST_OFF_CMD)) begin
                        op_q   <= i_wdata[1:0];
                        mode_q <= i_wdata[5:4];
                        case (i_wdata[1:0])
                            `HOST_OP_RAW_WR: st_q <= H_RAW_WR;
                            `HOST_OP_RAW_RD: st_q <= H_RAW_RD;
                            default:         st_q <= H_POLL;
                        endcase
                    end
                end
                H_POLL: begin
                    if (free) begin
                        io_addr_q <= `NV_OFF_CTRL; // R14
                        io_rd_q   <= 1'b1;
                        st_q      <= H_POLL_W;
                    end
                end
                H_POLL_W: st_q <= H_CHECK;
                H_CHECK: begin
                    st_q <= io.rdata[`NV_BIT_TRIG] ? H_POLL : H_SET_AL; // R14
                end
                H_SET_AL: begin
                    if (free) begin
                        io_addr_q  <= `NV_OFF_ADDR_LO; // R11 R15
                        io_wdata_q <= haddr_q[7:0];
                        io_wr_q    <= 1'b1;
                        st_q       <= H_SET_AH;
                    end
                end
                H_SET_AH: begin
                    if (free) begin
                        io_addr_q  <= `NV_OFF_ADDR_HI; // R11
                        io_wdata_q <= {7'h00, haddr_q[8]};
                        io_wr_q    <= 1'b1;
                        st_q       <= (op_q == `HOST_OP_READ) ? H_READ : H_SET_D;
                    end
                end
                H_SET_D: begin
                    if (free) begin
                        io_addr_q  <= `NV_OFF_DATA; // R12
                        io_wdata_q <= hdata_q;
                        io_wr_q    <= 1'b1;
                        st_q       <= H_SET_MODE;
                    end
                end
                H_SET_MODE: begin
                    if (free) begin
                        io_addr_q  <= `NV_OFF_CTRL; // R10
                        io_wdata_q <= ctrl_base;
                        io_wr_q    <= 1'b1;
                        st_q       <= H_ARM;
                    end
                end
                H_ARM: begin
                    if (free) begin
                        io_wdata_q <= ctrl_base | 8'h04; // R4
                        io_wr_q    <= 1'b1;
                        st_q       <= H_TRIG;
                    end
                end
                H_TRIG: begin
                    if (free) begin
                        io_wdata_q <= ctrl_base | 8'h02; // R4
                        io_wr_q    <= 1'b1;
                        st_q       <= H_IDLE;
                    end
                end
                H_READ: begin
                    if (free) begin
                        io_addr_q  <= `NV_OFF_CTRL; // R15
                        io_wdata_q <= ctrl_base | 8'h01;
                        io_wr_q    <= 1'b1;
                        st_q       <= H_RD_DATA;
                    end
                end
                H_RD_DATA: begin
                    if (free) begin
                        io_addr_q <= `NV_OFF_DATA; // R15
                        io_rd_q   <= 1'b1;
                        st_q      <= H_DATA_W;
                    end
                end
                H_DATA_W: st_q <= H_CAPTURE;
                H_CAPTURE: begin
                    result_q <= io.rdata;
                    st_q     <= H_IDLE;
                end
                H_RAW_WR: begin
                    if (free) begin
                        io_addr_q  <= haddr_q[5:0];
                        io_wdata_q <= hdata_q;
                        io_wr_q    <= 1'b1;
                        st_q       <= H_IDLE;
                    end
                end
                H_RAW_RD: begin
                    if (free) begin
                        io_addr_q <= haddr_q[5:0];
                        io_rd_q   <= 1'b1;
                        st_q      <= H_DATA_W;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign io.addr  = io_addr_q;
    assign io.wdata = io_wdata_q;
    assign io.wr    = io_wr_q;
    assign io.rd    = io_rd_q;
    assign io.gie   = gie_q;
    assign o_rdata  = rdata_q;
endmodule

// *** hdl/nv_defines.svh ***
// Constants for the byte-wide nonvolatile data store and its core port
// Summary of operation
// (R1) 512-byte separate store, each byte addressable
// (R2) Read start stalls core four cycles
// (R3) Program start stalls core two cycles
// (R4) Trigger only within four cycles after arm
// (R5) Mode zero: erase then write byte
// (R6) Trigger bit stays set until operation ends
// (R7) Busy store refuses reads and new triggers
// (R8) Mode 01: erase only while busy
// (R9) Mode 10: write only while busy
// (R10) Write-only needs previously erased byte
// (R11) Load address before triggering erase
// (R12) Load address and data before writing
// (R13) Program time from oscillator tick, not clock
// (R14) Poll busy clear before any new access (the host's raw read and raw write commands go out without a poll)
// (R15) Read: load address, set read bit, fetch data
// (R16) Atomic 3.4 ms, split 1.8 ms, 11 reserved
// (R17) Mode locked while busy; reset clears it (here reset clears mode only when the store is not busy)
// (R18) Nine-bit address split over two registers
// (R19) Ready interrupt level while enabled and idle
// (R20) Read bit self-clears; reads ignored while busy
// (R21) Arm clears itself after four cycles
`ifndef NV_DEFINES_SVH
`define NV_DEFINES_SVH

// Core-side register offsets
`define NV_OFF_CTRL      6'h1C
`define NV_OFF_DATA      6'h1D
`define NV_OFF_ADDR_LO   6'h1E
`define NV_OFF_ADDR_HI   6'h1F

// Control field positions
`define NV_BIT_MODE_HI   5
`define NV_BIT_MODE_LO   4
`define NV_BIT_RIE       3
`define NV_BIT_ARM       2
`define NV_BIT_TRIG      1
`define NV_BIT_READ      0

// Mode encodings and values
`define NV_MODE_ATOMIC   2'h0
`define NV_MODE_ERASE    2'h1
`define NV_MODE_WRITE    2'h2
`define NV_MODE_RSVD     2'h3
`define NV_MODE_RST      2'h0
`define NV_DATA_RST      8'h00
`define NV_ADDR_RST      9'h000
`define NV_ERASED        8'hFF
`define NV_BYTES         512

// Timing
`define NV_CLK_MHZ       40
`define NV_OSC_MHZ       8
`define NV_OSC_DIV       (`NV_CLK_MHZ / `NV_OSC_MHZ)
`define NV_T_ATOMIC_US   3400
`define NV_T_SPLIT_US    1800
`define NV_TIMER_W       16
`define NV_ARM_WINDOW    3'h4
`define NV_STALL_READ    3'h4
`define NV_STALL_PROG    3'h2

// Host command port offsets and opcodes
`define HOST_OFF_ADDR    2'h0
`define HOST_OFF_DATA    2'h1
`define HOST_OFF_CMD     2'h2
`define HOST_OFF_CFG     2'h3
`define HOST_OP_READ     2'h0
`define HOST_OP_PROG     2'h1
`define HOST_OP_RAW_WR   2'h2
`define HOST_OP_RAW_RD   2'h3

`endif

// *** hdl/nv_pkg.sv ***
// Types shared by both ends of the nonvolatile store port
package nv_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [8:0] nv_addr_type;
    typedef logic [5:0] io_addr_type;
    typedef enum {
        H_IDLE, H_POLL, H_POLL_W, H_CHECK, H_SET_AL, H_SET_AH, H_SET_D,
        H_SET_MODE, H_ARM, H_TRIG, H_READ, H_RD_DATA, H_DATA_W, H_CAPTURE,
        H_RAW_WR, H_RAW_RD
    } host_state_type;
endpackage

// *** hdl/nv_io_if.sv ***
// Core-to-store I/O register port
`timescale 1ns/1ps
interface nv_io_if;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       gie;
    logic [7:0] rdata;
    logic       stall;
    logic       ready_irq;
    modport device (input addr, wdata, wr, rd, gie, output rdata, stall, ready_irq);
    modport core (output addr, wdata, wr, rd, gie, input rdata, stall, ready_irq);
endinterface

// *** hdl/nv_store_device.sv ***
// Nonvolatile data store with its core-side control registers
`timescale 1ns/1ps
`include "nv_defines.svh"
module nv_store_device #(
    parameter int P_ATOMIC_TICKS = `NV_T_ATOMIC_US * `NV_OSC_MHZ,
    parameter int P_SPLIT_TICKS  = `NV_T_SPLIT_US * `NV_OSC_MHZ
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    nv_io_if.device   io,
    output wire logic o_busy
);
    import nv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    byte_type                mem_q [0:`NV_BYTES-1];
    nv_addr_type             addr_q;
    byte_type                data_q;
    logic [1:0]              mode_q;
    logic                    rie_q;
    logic [2:0]              arm_cnt_q;
    logic                    busy_q;
    logic [1:0]              op_mode_q;
    nv_addr_type             op_addr_q;
    byte_type                op_data_q;
    logic [`NV_TIMER_W-1:0]  timer_q;
    logic [2:0]              osc_cnt_q;
    logic                    osc_tick_q;
    logic [2:0]              stall_cnt_q;
    logic                    stall_q;
    byte_type                rdata_q;
    logic                    irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic                    ctrl_wr;
    logic                    arm_ok;
    logic                    prog_start;
    logic                    read_start;
    logic                    prog_done;
    logic [`NV_TIMER_W-1:0]  load_ticks;

    assign ctrl_wr    = io.wr && (io.addr == `NV_OFF_CTRL);
    assign arm_ok     = (arm_cnt_q != 3'h0);
    // Trigger honoured only inside the arm window, idle, non-reserved mode
    assign prog_start = ctrl_wr && io.wdata[`NV_BIT_TRIG] && arm_ok && !busy_q
                        && (mode_q != `NV_MODE_RSVD); // R4 R7 R16
    assign read_start = ctrl_wr && io.wdata[`NV_BIT_READ] && !busy_q
                        && !prog_start; // R7 R20
    assign prog_done  = busy_q && osc_tick_q && (timer_q == 16'h0001);
    // Duration by mode
    assign load_ticks = (mode_q == `NV_MODE_ATOMIC) ? 16'(P_ATOMIC_TICKS)
                                                    : 16'(P_SPLIT_TICKS); // R16

    ////////////////////////////////////////////////////////////////////////
    // Oscillator tick divider
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            osc_cnt_q  <= 3'h0;
            osc_tick_q <= 1'b0;
        end else if (osc_cnt_q == 3'(`NV_OSC_DIV - 1)) begin
            osc_cnt_q  <= 3'h0;
            osc_tick_q <= 1'b1; // R13
        end else begin
            osc_cnt_q  <= osc_cnt_q + 3'h1;
            osc_tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming sequencer; a running operation survives reset
    always_ff @(posedge i_clk) begin
        if (busy_q) begin
            if (osc_tick_q) begin
                timer_q <= timer_q - 16'h0001; // R13
            end
            if (prog_done) begin
                busy_q <= 1'b0; // R6
            end
        end else if (i_reset) begin
            busy_q    <= 1'b0;
            timer_q   <= 16'h0000;
            op_mode_q <= `NV_MODE_ATOMIC;
            op_addr_q <= `NV_ADDR_RST;
            op_data_q <= `NV_DATA_RST;
        end else if (prog_start) begin
            busy_q    <= 1'b1; // R6
            timer_q   <= load_ticks;
            op_mode_q <= mode_q;
            op_addr_q <= addr_q;
            op_data_q <= data_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte store update at the end of an operation
    always_ff @(posedge i_clk) begin
        if (prog_done) begin
            case (op_mode_q)
                `NV_MODE_ATOMIC: mem_q[op_addr_q] <= op_data_q; // R5 R1
                `NV_MODE_ERASE:  mem_q[op_addr_q] <= `NV_ERASED; // R8
                `NV_MODE_WRITE:  mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q; // R9
                default:         mem_q[op_addr_q] <= mem_q[op_addr_q];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address register, nine bits over two offsets
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            addr_q <= `NV_ADDR_RST;
        end else if (io.wr && (io.addr == `NV_OFF_ADDR_LO)) begin
            addr_q[7:0] <= io.wdata; // R18
        end else if (io.wr && (io.addr == `NV_OFF_ADDR_HI)) begin
            addr_q[8] <= io.wdata[0]; // R18
        end
    end

    // Data register: software write or read fetch
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            data_q <= `NV_DATA_RST;
        end else if (read_start) begin
            data_q <= mem_q[addr_q]; // R15 R20
        end else if (io.wr && (io.addr == `NV_OFF_DATA)) begin
            data_q <= io.wdata;
        end
    end

    // Mode field, locked while busy
    always_ff @(posedge i_clk) begin
        if (busy_q) begin
            mode_q <= mode_q; // R17
        end else if (i_reset) begin
            mode_q <= `NV_MODE_RST; // R17
        end else if (ctrl_wr) begin
            mode_q <= io.wdata[`NV_BIT_MODE_HI:`NV_BIT_MODE_LO];
        end
    end

    // Ready interrupt enable
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rie_q <= 1'b0;
        end else if (ctrl_wr) begin
            rie_q <= io.wdata[`NV_BIT_RIE];
        end
    end

    // Arm window counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            arm_cnt_q <= 3'h0;
        end else if (ctrl_wr && io.wdata[`NV_BIT_ARM]) begin
            arm_cnt_q <= `NV_ARM_WINDOW; // R4
        end else if (prog_start) begin
            arm_cnt_q <= 3'h0;
        end else if (arm_ok) begin
            arm_cnt_q <= arm_cnt_q - 3'h1; // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core stall after an accepted read start or program start
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            stall_cnt_q <= 3'h0;
            stall_q     <= 1'b0;
        end else if (read_start) begin
            stall_cnt_q <= `NV_STALL_READ; // R2
            stall_q     <= 1'b1;
        end else if (prog_start) begin
            stall_cnt_q <= `NV_STALL_PROG; // R3
            stall_q     <= 1'b1;
        end else begin
            if (stall_cnt_q != 3'h0) begin
                stall_cnt_q <= stall_cnt_q - 3'h1;
            end
            stall_q <= (stall_cnt_q > 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back, valid only in the cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_reset || !io.rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (io.addr)
                `NV_OFF_CTRL:    rdata_q <= {2'b00, mode_q, rie_q, arm_ok, busy_q, 1'b0};
                `NV_OFF_DATA:    rdata_q <= data_q;
                `NV_OFF_ADDR_LO: rdata_q <= addr_q[7:0];
                `NV_OFF_ADDR_HI: rdata_q <= {7'h00, addr_q[8]};
                default:         rdata_q <= 8'h00;
            endcase
        end
    end

    // Level ready interrupt
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= rie_q && io.gie && !busy_q; // R19
        end
    end

    assign io.rdata     = rdata_q;
    assign io.stall     = stall_q;
    assign io.ready_irq = irq_q;
    assign o_busy       = busy_q;
endmodule

// *** verification/nv_io_monitor.sv ***
// Checker on the core-to-store port
`timescale 1ns/1ps
`include "nv_defines.svh"
module nv_io_monitor #(
    parameter int P_ATOMIC_TICKS = `NV_T_ATOMIC_US * `NV_OSC_MHZ,
    parameter int P_SPLIT_TICKS  = `NV_T_SPLIT_US * `NV_OSC_MHZ
) (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       gie,
    input wire logic [7:0] rdata,
    input wire logic       stall,
    input wire logic       ready_irq,
    input wire logic       o_busy
);
    localparam int ATOMIC_CYC = P_ATOMIC_TICKS * `NV_OSC_DIV;
    localparam int SPLIT_CYC  = P_SPLIT_TICKS * `NV_OSC_DIV;
    logic        ctrl_wr;
    logic [3:0]  arm_age_q;
    logic [1:0]  mode_q;
    logic [17:0] busy_len_q;
    assign ctrl_wr = wr && (addr == `NV_OFF_CTRL);
    // Cycles since the last arm write, saturating
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            arm_age_q <= 4'hF;
        end else if (ctrl_wr && wdata[2]) begin
            arm_age_q <= 4'h0;
        end else if (arm_age_q != 4'hF) begin
            arm_age_q <= arm_age_q + 4'h1;
        end
    end
    // Mode as last accepted while idle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_q <= 2'h0;
        end else if (ctrl_wr && !o_busy) begin
            mode_q <= wdata[5:4];
        end
    end
    // Length of the current busy period
    always_ff @(posedge i_clk) begin
        busy_len_q <= o_busy ? busy_len_q + 18'h0_0001 : 18'h0_0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    read_stall_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ctrl_wr && wdata[0] && !wdata[1] && !o_busy |=> stall [*4] ##1 !stall)
        else $error("read start did not stall four cycles");
    prog_stall_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_busy) |-> stall [*2] ##1 !stall)
        else $error("program start did not stall two cycles");
    arm_window_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_busy) |-> arm_age_q <= 4'h4 && $past(ctrl_wr && wdata[1]))
        else $error("program began outside the arm window");
    busy_guard_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(stall) |-> !$past(o_busy))
        else $error("access accepted while busy");
    busy_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rd && addr == `NV_OFF_CTRL |=> rdata[1] == $past(o_busy))
        else $error("trigger bit does not follow busy");
    busy_time_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(o_busy) |-> (mode_q == 2'h0)
            ? (busy_len_q >= ATOMIC_CYC - 6 && busy_len_q <= ATOMIC_CYC + 6)
            : (busy_len_q >= SPLIT_CYC - 6 && busy_len_q <= SPLIT_CYC + 6))
        else $error("busy period has the wrong length");
    rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
        !rd |=> rdata == 8'h00)
        else $error("read data outside the answer cycle");
    ready_level_a: assert property (@(posedge i_clk) disable iff (i_reset)
        ready_irq |-> $past(gie) && !$past(o_busy))
        else $error("ready interrupt without enable or while busy");
endmodule

// *** verification/eeprom_byte_access_ctrl_tb_top.sv ***
// Bench for the byte store driven through its core-side sequencer
`timescale 1ns/1ps
`include "nv_defines.svh"
module eeprom_byte_access_ctrl_tb_top;
    logic        i_clk;
    logic        i_reset;
    logic [1:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [15:0] o_rdata;
    logic        o_busy;
    logic [15:0] got;
    int          err_total;
    int          n_compared;
    int          cycles;
    logic [8:0]  t_addr [5] = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h000, 9'h1FF};
    logic [1:0]  t_mode [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
    logic [7:0]  t_data [5] = '{8'hA5, 8'h00, 8'h3C, 8'h5A, 8'h00};
    logic [7:0]  t_exp  [5] = '{8'hA5, 8'hFF, 8'h3C, 8'h5A, 8'h3C};
    nv_io_if nv_io_if_i ();
    nv_store_device #(.P_ATOMIC_TICKS(20), .P_SPLIT_TICKS(10)) nv_store_device_i (
        .i_clk(i_clk), .i_reset(i_reset), .io(nv_io_if_i.device), .o_busy(o_busy));
    nv_core_host nv_core_host_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .io(nv_io_if_i.core));
    nv_io_monitor #(.P_ATOMIC_TICKS(20), .P_SPLIT_TICKS(10)) nv_io_monitor_i (
        .i_clk(i_clk), .i_reset(i_reset), .addr(nv_io_if_i.addr),
        .wdata(nv_io_if_i.wdata), .wr(nv_io_if_i.wr), .rd(nv_io_if_i.rd),
        .gie(nv_io_if_i.gie), .rdata(nv_io_if_i.rdata), .stall(nv_io_if_i.stall),
        .ready_irq(nv_io_if_i.ready_irq), .o_busy(o_busy));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic host_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic host_rd(input logic [1:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        got = o_rdata;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // Load address and data, issue a command, poll until the host is idle
    task automatic host_cmd(input logic [8:0] a, input logic [7:0] d, input logic [15:0] c);
        host_wr(`HOST_OFF_ADDR, {7'h00, a});
        host_wr(`HOST_OFF_DATA, {8'h00, d});
        host_wr(`HOST_OFF_CMD, c);
        got = 16'h0001;
        while (got[0] !== 1'b0) begin
            host_rd(`HOST_OFF_CMD);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_addr  = 2'h0;
        i_wdata = 16'h0000;
        i_wr    = 1'b0;
        i_rd    = 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        host_rd(`HOST_OFF_CMD);
        check("status after reset", 16'h0000, got);
        host_wr(`HOST_OFF_CFG, 16'h0003);
        // Every mode, both address ends, reserved mode refused
        for (int i = 0; i < 5; i++) begin
            host_cmd(t_addr[i], t_data[i], {10'h000, t_mode[i], 4'h1});
            host_cmd(t_addr[i], 8'h00, 16'h0000);
            check("stored byte", {8'h00, t_exp[i]}, {8'h00, got[15:8]});
        end
        check("ready irq enabled", 16'h0002, got & 16'h0002);
        host_wr(`HOST_OFF_CFG, 16'h0002);
        host_rd(`HOST_OFF_CMD);
        check("ready irq masked", 16'h0000, got & 16'h0002);
        host_wr(`HOST_OFF_CFG, 16'h0003);
        // Read start and trigger while programming are refused, mode is locked
        host_cmd(9'h010, 8'h77, 16'h0001);
        host_cmd(9'h01C, 8'h00, 16'h0003);
        check("ctrl while busy", 16'h000A, {8'h00, got[15:8]});
        host_cmd(9'h01C, 8'h1A, 16'h0002);
        host_cmd(9'h01C, 8'h00, 16'h0003);
        check("mode while busy", 16'h000A, {8'h00, got[15:8]});
        host_cmd(9'h01C, 8'h09, 16'h0002);
        host_cmd(9'h01D, 8'h00, 16'h0003);
        check("data while busy", 16'h0077, {8'h00, got[15:8]});
        host_cmd(9'h010, 8'h00, 16'h0000);
        check("byte after refusals", 16'h0077, {8'h00, got[15:8]});
        host_cmd(9'h01C, 8'h00, 16'h0003);
        check("ctrl after busy", 16'h0008, {8'h00, got[15:8]});
        // Trigger long after arm has no effect, arm lapses, ready enable kept
        host_cmd(9'h01C, 8'h0C, 16'h0002);
        host_cmd(9'h01C, 8'h0A, 16'h0002);
        host_cmd(9'h01C, 8'h00, 16'h0003);
        check("ctrl after late trigger", 16'h0008, {8'h00, got[15:8]});
        host_cmd(9'h010, 8'h00, 16'h0000);
        check("byte after late trigger", 16'h0077, {8'h00, got[15:8]});
        wrap_up;
    end
endmodule
